// File: hw/bdm_data_memory.sv
// Banked data memory: core registers, general storage and address decode.
// Assumes the core datapath on the same clock drives the access port;
// peripheral registers live elsewhere and read as zero here.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - General storage is 128 bytes, or 192 bytes in the larger variant.
// - Every location reachable directly or through the indirect pointer.
// - Unimplemented addresses read zero; writes there do nothing.
// - Stored values hold until written or changed by their owner.
// - Two bank select bits choose bank 0 to 3.
// - Each bank spans offsets 00h to 7Fh.
// - Function registers sit lowest; general storage above them.
// - Core registers are mirrored at the same offset in every bank.
module bdm_data_memory #(
	parameter int STORAGE_BYTES = 192
) (
	input  wire logic                      clk_sys,
	input  wire logic                      rst_n,
	input  wire logic [bdm_pkg::OFS_W-1:0] accOffset,
	input  wire logic                      accRead,
	input  wire logic                      accWrite,
	input  wire logic [7:0]                accWdata,
	input  wire logic [2:0]                aluFlagWe,
	input  wire logic [2:0]                aluFlags,
	input  wire logic                      pcLowLoad,
	input  wire logic [7:0]                pcLowIn,
	input  wire logic                      timeoutFlag,
	input  wire logic                      powerDownFlag,
	output logic [7:0]                     rdData,
	output logic                           rdValid,
	output logic [1:0]                     bankSel,
	output logic [7:0]                     indirectPointer,
	output logic [7:0]                     coreFlags,
	output logic [7:0]                     pcLow,
	output logic [7:0]                     pcLatchHigh,
	output logic [7:0]                     interruptControl
);
	import bdm_pkg::*;

	// Only the two storage sizes have a bank layout
	if (STORAGE_BYTES != STORAGE_SMALL && STORAGE_BYTES != STORAGE_LARGE) begin : g_bad_size
		$error("STORAGE_BYTES must be 128 or 192");
	end

	localparam bit LARGE = (STORAGE_BYTES == STORAGE_LARGE);

	logic [7:0]        storage [STORAGE_BYTES];
	logic [7:0]        rdData_reg;
	logic              rdValid_reg;
	logic [7:0]        flags_reg;
	logic [7:0]        ptr_reg;
	logic [7:0]        pcLow_reg;
	logic [7:0]        pcLatch_reg;
	logic [7:0]        intCtl_reg;

	logic [ADDR_W-1:0] effAddr;
	logic [1:0]        effBank;
	logic [6:0]        effOfs;
	logic              hitStorage;
	logic [7:0]        storageIdx;
	logic [7:0]        rdNext;
	logic              isCore;

	// indirect resolve
	// Offset zero is the window; the pointer plus bank bit give the real address
	// Flag bit 7 lifts the pointer into the upper bank pair
	always_comb begin
		if (accOffset == OFS_INDIRECT_WINDOW)
			effAddr = {flags_reg[FLAG_INDIRECT_BANK], ptr_reg};
		else
			effAddr = {flags_reg[FLAG_BANK_HIGH], flags_reg[FLAG_BANK_LOW], accOffset};
		effBank = effAddr[8:7];
		effOfs  = effAddr[6:0];
	end

	assign bankSel = {flags_reg[FLAG_BANK_HIGH], flags_reg[FLAG_BANK_LOW]};

	always_comb begin
		hitStorage = 1'b0;
		storageIdx = 8'h00;
		if (effOfs >= OFS_COMMON_FIRST) begin
			hitStorage = 1'b1;
			storageIdx = {1'b0, effOfs - OFS_STORAGE_FIRST};
		end else if (effOfs >= OFS_STORAGE_FIRST) begin
			unique case (effBank)
				BANK_0: begin
					hitStorage = 1'b1;
					storageIdx = {1'b0, effOfs - OFS_STORAGE_FIRST};
				end
				BANK_1: begin
					hitStorage = LARGE ? (effOfs < OFS_BANK1_END_LARGE)
						: (effOfs < OFS_BANK1_END_SMALL);
					storageIdx = IDX_BANK1_BASE + {1'b0, effOfs - OFS_STORAGE_FIRST};
				end
				BANK_2: begin
					hitStorage = LARGE && (effOfs < OFS_BANK2_END_LARGE);
					storageIdx = IDX_BANK2_BASE + {1'b0, effOfs - OFS_STORAGE_FIRST};
				end
				// Bank 3 holds only the common area
				default: begin
					hitStorage = 1'b0;
					storageIdx = 8'h00;
				end
			endcase
		end
	end

	always_comb begin
		isCore = 1'b1;
		rdNext = 8'h00;
		unique case (effOfs)
			OFS_PC_LOW:         rdNext = pcLow_reg;
			OFS_CORE_FLAGS:     rdNext = flags_reg;
			OFS_INDIRECT_PTR:   rdNext = ptr_reg;
			OFS_PC_LATCH_HIGH:  rdNext = pcLatch_reg;
			OFS_INTERRUPT_CTRL: rdNext = intCtl_reg;
			default:            isCore = 1'b0;
		endcase
		// unimplemented reads zero
		// A window pointing at itself is no physical register
		if (!isCore) begin
			if (hitStorage && effOfs != OFS_INDIRECT_WINDOW)
				rdNext = storage[storageIdx];
			else
				rdNext = 8'h00;
		end
	end

	logic wrCore;
	logic wrFlags;
	logic wrStorage;
	// A write through the window lands wherever the pointer points
	assign wrCore = accWrite && isCore;
	assign wrFlags = wrCore && effOfs == OFS_CORE_FLAGS;
	assign wrStorage = accWrite && hitStorage && !isCore;

	// Read answer one cycle after the request
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			rdValid_reg <= 1'b0;
		else
			rdValid_reg <= accRead;
	end

	// Data stands until the next read, so a slow consumer may look late
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			rdData_reg <= 8'h00;
		else if (accRead)
			rdData_reg <= rdNext;
	end

	// static storage
	// No reset on the array so it maps to plain RAM
	always_ff @(posedge clk_sys) begin
		if (wrStorage)
			storage[storageIdx] <= accWdata;
	end

	// owner updates flags
	// Result flags from the ALU win over a plain store; sleep flags are read only
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			flags_reg <= RST_CORE_FLAGS;
		end else begin
			if (wrFlags)
				flags_reg[7:5] <= accWdata[7:5];
			for (int i = 0; i < 3; i++) begin
				if (aluFlagWe[i])
					flags_reg[i] <= aluFlags[i];
				else if (wrFlags)
					flags_reg[i] <= accWdata[i];
			end
			flags_reg[FLAG_TIMEOUT]    <= timeoutFlag;
			flags_reg[FLAG_POWER_DOWN] <= powerDownFlag;
		end
	end

	// program counter owner
	// Core load wins: a branch overrides a store in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			pcLow_reg <= RST_PC_LOW;
		else if (pcLowLoad)
			pcLow_reg <= pcLowIn;
		else if (wrCore && effOfs == OFS_PC_LOW)
			pcLow_reg <= accWdata;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			ptr_reg <= RST_INDIRECT_PTR;
		else if (wrCore && effOfs == OFS_INDIRECT_PTR)
			ptr_reg <= accWdata;
	end

	// latch store
	// Only the bus writes it; the core copies it out on a jump
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			pcLatch_reg <= RST_PC_LATCH_HIGH;
		else if (wrCore && effOfs == OFS_PC_LATCH_HIGH)
			pcLatch_reg <= accWdata;
	end

	// interrupt control store
	// Peripheral request bits are not merged here; the bus owns every bit
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			intCtl_reg <= RST_INTERRUPT_CTRL;
		else if (wrCore && effOfs == OFS_INTERRUPT_CTRL)
			intCtl_reg <= accWdata;
	end

	assign rdData           = rdData_reg;
	assign rdValid          = rdValid_reg;
	assign indirectPointer  = ptr_reg;
	assign coreFlags        = flags_reg;
	assign pcLow            = pcLow_reg;
	assign pcLatchHigh      = pcLatch_reg;
	assign interruptControl = intCtl_reg;
endmodule

`default_nettype wire

// File: hw/bdm_pkg.sv
// Package for the banked data memory map: offsets, layout and reset values.
// Assumes a single core clock domain; shared by bdm_data_memory and the bench top.
package bdm_pkg;
	localparam int ADDR_W = 9;
	localparam int OFS_W  = 7;

	// Core register offsets, mirrored in every bank
	localparam logic [6:0] OFS_INDIRECT_WINDOW = 7'h00;
	localparam logic [6:0] OFS_PC_LOW          = 7'h02;
	localparam logic [6:0] OFS_CORE_FLAGS      = 7'h03;
	localparam logic [6:0] OFS_INDIRECT_PTR    = 7'h04;
	localparam logic [6:0] OFS_PC_LATCH_HIGH   = 7'h0a;
	localparam logic [6:0] OFS_INTERRUPT_CTRL  = 7'h0b;

	// General storage layout within a bank
	localparam logic [6:0] OFS_STORAGE_FIRST  = 7'h20;
	localparam logic [6:0] OFS_COMMON_FIRST   = 7'h70;
	localparam logic [6:0] OFS_BANK1_END_SMALL = 7'h40;
	localparam logic [6:0] OFS_BANK1_END_LARGE = 7'h70;
	localparam logic [6:0] OFS_BANK2_END_LARGE = 7'h30;
	localparam logic [7:0] IDX_BANK1_BASE     = 8'h60;
	localparam logic [7:0] IDX_BANK2_BASE     = 8'hb0;
	localparam int STORAGE_SMALL = 128;
	localparam int STORAGE_LARGE = 192;

	// Bank numbers
	localparam logic [1:0] BANK_0 = 2'h0;
	localparam logic [1:0] BANK_1 = 2'h1;
	localparam logic [1:0] BANK_2 = 2'h2;

	// Core flag field positions
	localparam int FLAG_INDIRECT_BANK = 7;
	localparam int FLAG_BANK_HIGH     = 6;
	localparam int FLAG_BANK_LOW      = 5;
	localparam int FLAG_TIMEOUT       = 4;
	localparam int FLAG_POWER_DOWN    = 3;

	// Values after reset
	localparam logic [7:0] RST_PC_LOW          = 8'h00;
	localparam logic [7:0] RST_CORE_FLAGS      = 8'h18;
	localparam logic [7:0] RST_INDIRECT_PTR    = 8'h00;
	localparam logic [7:0] RST_PC_LATCH_HIGH   = 8'h00;
	localparam logic [7:0] RST_INTERRUPT_CTRL  = 8'h00;
endpackage

// File: tb/banked_data_memory_map_tb_top.sv
// Bench for the banked data memory, larger storage variant.
// Core side driven through the core stand-in model.
`timescale 1ns/1ps
`default_nettype none
module banked_data_memory_map_tb_top;
	import bdm_pkg::*;
	logic       clk_sys;
	logic       rst_n;
	logic       timeoutFlag;
	logic       powerDownFlag;
	logic       pcLowLoad;
	logic [2:0] aluFlagWe;
	logic [2:0] aluFlags;
	logic [7:0] pcLowIn;
	logic [7:0] interruptControl;
	logic       accRead;
	logic       accWrite;
	logic       rdValid;
	logic       v;
	logic [6:0] accOffset;
	logic [7:0] accWdata;
	logic [7:0] rdData;
	logic [7:0] q;
	logic [1:0] bankSel;
	logic [7:0] coreFlags;
	logic [7:0] indirectPointer;
	logic [7:0] pcLow;
	logic [7:0] pcLatchHigh;
	int         error_cnt;
	int         checks;
	bdm_data_memory #(.STORAGE_BYTES(192)) i_dut (.clk_sys, .rst_n, .accOffset, .accRead,
		.accWrite, .accWdata, .aluFlagWe, .aluFlags, .pcLowLoad, .pcLowIn, .timeoutFlag,
		.powerDownFlag, .rdData, .rdValid, .bankSel, .indirectPointer, .coreFlags, .pcLow,
		.pcLatchHigh, .interruptControl);
	bdm_core_model i_core (.clk_sys, .rdData, .rdValid, .accOffset, .accRead, .accWrite,
		.accWdata);
	task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bank(input logic [1:0] b);
		i_core.wr(OFS_CORE_FLAGS, {1'b0, b, 5'h00});
	endtask
	task automatic rdchk(input string n, input logic [6:0] o, input logic [7:0] e);
		i_core.rd(o, v, q);
		check(n, {7'h00, v}, 8'h01);
		check(n, q, e);
	endtask
	task automatic t_reset;
		check("flags", coreFlags, RST_CORE_FLAGS);
		check("pointer", indirectPointer, RST_INDIRECT_PTR);
		check("pc low", pcLow, RST_PC_LOW);
	endtask
	task automatic t_banks;
		for (int b = 0; b < 4; b++) begin
			bank(2'(b));
			@(negedge clk_sys);
			check("bank", {6'h00, bankSel}, 8'(b));
			i_core.wr(7'h7c + 7'(b), 8'ha0 + 8'(b));
			i_core.wr(OFS_PC_LATCH_HIGH, 8'h10 + 8'(b));
			i_core.wr(OFS_STORAGE_FIRST, 8'h50 + 8'(b));
			// Bank 3 holds only the common area, so OFS_STORAGE_FIRST reads back zero
			rdchk("store", OFS_STORAGE_FIRST, (b == 3) ? 8'h00 : 8'h50 + 8'(b));
		end
		bank(BANK_0);
		rdchk("mirror", OFS_PC_LATCH_HIGH, 8'h13);
		for (int b = 0; b < 4; b++) begin
			rdchk("common", 7'h7c + 7'(b), 8'ha0 + 8'(b));
		end
		i_core.wr(7'h01, 8'hff);
		rdchk("unused", 7'h01, 8'h00);
	endtask
	task automatic t_indirect;
		i_core.wr(OFS_INDIRECT_PTR, 8'ha0);
		rdchk("indirect", OFS_INDIRECT_WINDOW, 8'h51);
		i_core.wr(OFS_INDIRECT_WINDOW, 8'h3c);
		bank(BANK_1);
		rdchk("direct", OFS_STORAGE_FIRST, 8'h3c);
	endtask
	task automatic t_owner;
		i_core.wr(OFS_CORE_FLAGS, 8'h80);
		i_core.wr(OFS_INDIRECT_PTR, 8'h20);
		rdchk("indirect upper", OFS_INDIRECT_WINDOW, 8'h52);
		i_core.wr(OFS_INDIRECT_PTR, 8'ha0);
		rdchk("indirect empty", OFS_INDIRECT_WINDOW, 8'h00);
		i_core.wr(OFS_INTERRUPT_CTRL, 8'hc5);
		@(negedge clk_sys);
		check("interrupt control", interruptControl, 8'hc5);
		rdchk("interrupt read", OFS_INTERRUPT_CTRL, 8'hc5);
		// Core load and bus store in one cycle: the load wins
		fork
			i_core.wr(OFS_PC_LOW, 8'h5a);
			begin
				@(posedge clk_sys);
				pcLowLoad <= 1'b1;
				pcLowIn <= 8'h77;
				@(posedge clk_sys);
				pcLowLoad <= 1'b0;
			end
		join
		rdchk("pc load", OFS_PC_LOW, 8'h77);
		i_core.wr(OFS_PC_LOW, 8'h5a);
		@(negedge clk_sys);
		check("pc low store", pcLow, 8'h5a);
		@(posedge clk_sys);
		powerDownFlag <= 1'b0;
		// Result flag enables win over a bus store to the same bit
		fork
			i_core.wr(OFS_CORE_FLAGS, 8'h07);
			begin
				@(posedge clk_sys);
				aluFlagWe <= 3'h5;
				@(posedge clk_sys);
				aluFlagWe <= 3'h0;
			end
		join
		@(negedge clk_sys);
		check("flags owner", coreFlags, 8'h02);
		@(posedge clk_sys);
		powerDownFlag <= 1'b1;
		repeat (2) @(negedge clk_sys);
		check("sleep flag", coreFlags, 8'h0a);
	endtask
	task automatic wrap_up;
		if (error_cnt == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial begin
		rst_n = 1'b0;
		timeoutFlag = 1'b1;
		powerDownFlag = 1'b1;
		pcLowLoad = 1'b0;
		pcLowIn = 8'h00;
		aluFlagWe = 3'h0;
		aluFlags = 3'h0;
		error_cnt = 0;
		checks = 0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(negedge clk_sys);
		t_reset();
		t_banks();
		@(posedge clk_sys);
		timeoutFlag <= 1'b0;
		t_indirect();
		t_owner();
		wrap_up();
	end
endmodule
bind bdm_data_memory bdm_data_memory_properties i_chk (.clk_sys, .rst_n, .accOffset,
	.accRead, .accWrite, .accWdata, .timeoutFlag, .powerDownFlag, .pcLowLoad, .pcLowIn,
	.rdData, .rdValid, .bankSel, .indirectPointer, .coreFlags, .pcLow, .pcLatchHigh);
`default_nettype wire

// File: tb/bdm_core_model.sv
// Core datapath stand-in issuing direct and indirect accesses.
// Assumes one-cycle read answers from the memory.
`timescale 1ns/1ps
`default_nettype none
module bdm_core_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] rdData,
	input  wire logic       rdValid,
	output var  logic [6:0] accOffset,
	output var  logic       accRead,
	output var  logic       accWrite,
	output var  logic [7:0] accWdata
);
	initial begin
		accOffset = 7'h7f;
		accRead = 1'b0;
		accWrite = 1'b0;
		accWdata = 8'h00;
	end
	task automatic wr(input logic [6:0] o, input logic [7:0] d);
		@(posedge clk_sys);
		accOffset <= o;
		accWdata <= d;
		accWrite <= 1'b1;
		@(posedge clk_sys);
		accWrite <= 1'b0;
		// Released data shows junk, not the last byte
		accWdata <= ~d;
	endtask
	task automatic rd(input logic [6:0] o, output logic v, output logic [7:0] q);
		@(posedge clk_sys);
		accOffset <= o;
		accRead <= 1'b1;
		@(posedge clk_sys);
		accRead <= 1'b0;
		@(negedge clk_sys);
		v = rdValid;
		q = rdData;
	endtask
endmodule
`default_nettype wire

// File: tb/bdm_data_memory_properties.sv
// Port assertions for the banked data memory.
// Bound to the design from the bench top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module bdm_data_memory_properties (
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic [6:0] accOffset,
	input wire logic       accRead,
	input wire logic       accWrite,
	input wire logic [7:0] accWdata,
	input wire logic       timeoutFlag,
	input wire logic       powerDownFlag,
	input wire logic       pcLowLoad,
	input wire logic [7:0] pcLowIn,
	input wire logic [7:0] rdData,
	input wire logic       rdValid,
	input wire logic [1:0] bankSel,
	input wire logic [7:0] indirectPointer,
	input wire logic [7:0] coreFlags,
	input wire logic [7:0] pcLow,
	input wire logic [7:0] pcLatchHigh
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_wr(logic [6:0] o);
		accWrite && accOffset == o;
	endsequence
	chk_read_answer: assert property (accRead |=> rdValid)
		else $error("read not answered");
	chk_no_spurious: assert property (!accRead |=> !rdValid)
		else $error("answer without read");
	chk_unused_zero: assert property (accRead && accOffset == 7'h01 |=> rdData == 8'h00)
		else $error("unused offset not zero");
	chk_rd_holds: assert property (!accRead |=> $stable(rdData))
		else $error("read data moved");
	chk_ptr_static: assert property (!accWrite |=> $stable(indirectPointer))
		else $error("pointer moved");
	chk_ptr_write: assert property (s_wr(7'h04) |=> indirectPointer == $past(accWdata))
		else $error("pointer write lost");
	chk_latch_write: assert property (s_wr(7'h0a) |=> pcLatchHigh == $past(accWdata))
		else $error("latch write lost");
	chk_bank_select: assert property (s_wr(7'h03) |=> bankSel == $past(accWdata[6:5]))
		else $error("bank select wrong");
	chk_flag_copy: assert property (1'b1 |=> coreFlags[4] == $past(timeoutFlag))
		else $error("timeout flag not copied");
	chk_pc_load: assert property (pcLowLoad |=> pcLow == $past(pcLowIn))
		else $error("core load lost");
	chk_sleep_copy: assert property (1'b1 |=> coreFlags[3] == $past(powerDownFlag))
		else $error("power down flag not copied");
endmodule
`default_nettype wire
